// File: core/ptpe_pkg.sv
// package for the tap position codec: code map constants and the wiper carrier type
package ptpe_pkg;
   localparam int unsigned TAP_COUNT        = 100;
   localparam int unsigned BLOCK_SIZE       = 25;
   localparam logic [7:0]  BLK1_FIRST_TAP   = 8'h19;
   localparam logic [7:0]  BLK2_FIRST_TAP   = 8'h32;
   localparam logic [7:0]  BLK3_FIRST_TAP   = 8'h4B;
   localparam logic [7:0]  LAST_TAP         = 8'h63;
   localparam logic [7:0]  BLK1_REFLECT     = 8'h51;   // 81
   localparam logic [7:0]  BLK2_OFFSET      = 8'h0E;   // 14
   localparam logic [7:0]  BLK3_REFLECT     = 8'hC3;   // 195
   localparam logic [7:0]  CODE_MIN         = 8'h00;
   localparam logic [7:0]  CODE_MAX_POS     = 8'h60;   // 96
   localparam logic [7:0]  BLK0_CODE_HI     = 8'h18;
   localparam logic [7:0]  BLK1_CODE_LO     = 8'h20;
   localparam logic [7:0]  BLK1_CODE_HI     = 8'h38;
   localparam logic [7:0]  BLK2_CODE_LO     = 8'h40;
   localparam logic [7:0]  BLK2_CODE_HI     = 8'h58;
   localparam logic [7:0]  BLK3_CODE_LO     = 8'h60;
   localparam logic [7:0]  BLK3_CODE_HI     = 8'h78;
   // recall delay window after supply rise, in microseconds
   localparam int unsigned RECALL_MIN_US    = 700;
   localparam int unsigned RECALL_MAX_US    = 1300;
   localparam int unsigned CLK_MHZ          = 10;
   localparam int unsigned RECALL_MIN_CYC   = RECALL_MIN_US * CLK_MHZ;
   localparam int unsigned RECALL_MAX_CYC   = RECALL_MAX_US * CLK_MHZ;
   localparam int unsigned RECALL_CYC_DEF   = (RECALL_MIN_CYC + RECALL_MAX_CYC) / 2;

   // decoded wiper selection
   typedef struct packed {
      logic       valid;
      logic [6:0] tap;
   } ptpe_wiper_type;
endpackage

// File: core/ptpe_tap_codec.sv
// tap position codec for the fine step potentiometer, with power-up recall
// Overview of operation
// - taps 0 to 24 encode as the tap number itself
// - taps 25 to 49 encode as 81 minus tap, 56 down to 32
// - taps 50 to 74 encode as tap plus 14, 64 up to 88
// - taps 75 to 99 encode as 195 minus tap, 120 down to 96
// - wiper restored from storage 0.7 to 1.3 ms after power-up
`timescale 1ns/1ps
`default_nettype none
module ptpe_tap_codec
   import ptpe_pkg::*;
#(
   parameter int unsigned RECALL_CYCLES = RECALL_CYC_DEF
)(
   input  wire  logic                    clk_sys,
   input  wire  logic                    rst,
   input  wire  logic [7:0]              wiper_code,
   input  wire  logic                    wiper_write,
   input  wire  logic [7:0]              stored_code,
   output logic                          recall_done,
   output ptpe_pkg::ptpe_wiper_type      fine_step_potentiometer
);
   import ptpe_pkg::*;

   // refuse a recall delay outside the 0.7 to 1.3 ms recall window; checked once at elaboration
   if (RECALL_CYCLES < RECALL_MIN_CYC || RECALL_CYCLES > RECALL_MAX_CYC)
   begin : g_recall_range
      $error("recall delay outside the allowed window");
   end

   // code to tap; returns valid low for any code outside the four runs
   function automatic ptpe_wiper_type code_to_tap(input logic [7:0] c);
      ptpe_wiper_type r;
      r = '0;
      if (c <= BLK0_CODE_HI)
      begin
         r = '{1'b1, c[6:0]};
      end
      else if (c >= BLK1_CODE_LO && c <= BLK1_CODE_HI)
      begin
         r = '{1'b1, 7'(BLK1_REFLECT - c)};
      end
      else if (c >= BLK2_CODE_LO && c <= BLK2_CODE_HI)
      begin
         r = '{1'b1, 7'(c - BLK2_OFFSET)};
      end
      else if (c >= BLK3_CODE_LO && c <= BLK3_CODE_HI)
      begin
         r = '{1'b1, 7'(BLK3_REFLECT - c)};
      end
      return r;
   endfunction

   // tap to code, used only to check the round trip
   function automatic logic [7:0] tap_to_code(input logic [6:0] t);
      logic [7:0] tt;
      tt = {1'b0, t};
      if (tt < BLK1_FIRST_TAP)
         return tt;
      else if (tt < BLK2_FIRST_TAP)
         return 8'(BLK1_REFLECT - tt);
      else if (tt < BLK3_FIRST_TAP)
         return 8'(tt + BLK2_OFFSET);
      else
         return 8'(BLK3_REFLECT - tt);
   endfunction

   localparam int CW = $clog2(RECALL_MAX_CYC + 1);

   logic [CW-1:0]   pu_cnt_q;
   logic            done_q;
   ptpe_wiper_type  wiper_q;

   // power-up recall timer; reset stands for the supply rise
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pu_cnt_q <= '0;
         done_q   <= 1'b0;
      end
      else if (!done_q)
      begin
         if (pu_cnt_q == CW'(RECALL_CYCLES - 1))
            done_q <= 1'b1;
         pu_cnt_q <= pu_cnt_q + 1'b1;
      end
   end

   // wiper register: recall at timer end, host writes only after recall
   // a write during the recall window is dropped, the stored value wins
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         wiper_q <= '0;
      else if (!done_q && pu_cnt_q == CW'(RECALL_CYCLES - 1))
         wiper_q <= code_to_tap(stored_code);
      else if (done_q && wiper_write)
         wiper_q <= code_to_tap(wiper_code);
   end

   assign recall_done             = done_q;
   assign fine_step_potentiometer = wiper_q;

   // checks
   property p_recall_time;
      @(posedge clk_sys) disable iff (rst)
      $rose(done_q) |-> (pu_cnt_q == CW'(RECALL_CYCLES));
   endproperty
   a_recall_time: assert property (p_recall_time)
      else $error("recall finished at wrong time");

   property p_recall_load;
      @(posedge clk_sys) disable iff (rst)
      (!done_q && pu_cnt_q == CW'(RECALL_CYCLES - 1)) |=>
         (wiper_q == code_to_tap($past(stored_code)));
   endproperty
   a_recall_load: assert property (p_recall_load)
      else $error("recalled wiper wrong");

   property p_blk0;
      @(posedge clk_sys) disable iff (rst)
      (done_q && wiper_write && wiper_code <= BLK0_CODE_HI) |=>
         (wiper_q.valid && {1'b0, wiper_q.tap} == $past(wiper_code));
   endproperty
   a_blk0: assert property (p_blk0)
      else $error("low block decode wrong");

   property p_blk1;
      @(posedge clk_sys) disable iff (rst)
      (done_q && wiper_write && wiper_code >= BLK1_CODE_LO && wiper_code <= BLK1_CODE_HI)
         |=> (wiper_q.valid && 8'(wiper_q.tap + $past(wiper_code)) == BLK1_REFLECT);
   endproperty
   a_blk1: assert property (p_blk1)
      else $error("second block decode wrong");

   property p_blk2;
      @(posedge clk_sys) disable iff (rst)
      (done_q && wiper_write && wiper_code >= BLK2_CODE_LO && wiper_code <= BLK2_CODE_HI)
         |=> (wiper_q.valid && 8'(wiper_q.tap + BLK2_OFFSET) == $past(wiper_code));
   endproperty
   a_blk2: assert property (p_blk2)
      else $error("third block decode wrong");

   property p_blk3;
      @(posedge clk_sys) disable iff (rst)
      (done_q && wiper_write && wiper_code >= BLK3_CODE_LO && wiper_code <= BLK3_CODE_HI)
         |=> (wiper_q.valid && 8'(wiper_q.tap + $past(wiper_code)) == BLK3_REFLECT);
   endproperty
   a_blk3: assert property (p_blk3)
      else $error("top block decode wrong");

   property p_round_trip;
      @(posedge clk_sys) disable iff (rst)
      wiper_q.valid |-> (wiper_q.tap <= LAST_TAP[6:0]
         && code_to_tap(tap_to_code(wiper_q.tap)) == wiper_q);
   endproperty
   a_round_trip: assert property (p_round_trip)
      else $error("selected tap out of range");

   property p_invalid;
      @(posedge clk_sys) disable iff (rst)
      (done_q && wiper_write && (wiper_code > BLK3_CODE_HI
         || (wiper_code > BLK0_CODE_HI && wiper_code < BLK1_CODE_LO)
         || (wiper_code > BLK1_CODE_HI && wiper_code < BLK2_CODE_LO)
         || (wiper_code > BLK2_CODE_HI && wiper_code < BLK3_CODE_LO))) |=> !wiper_q.valid;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("undefined code gave a tap");

   property p_no_early_write;
      @(posedge clk_sys) disable iff (rst)
      (!done_q && !(pu_cnt_q == CW'(RECALL_CYCLES - 1))) |=> $stable(wiper_q);
   endproperty
   a_no_early_write: assert property (p_no_early_write)
      else $error("wiper changed before recall");

   // once recalled the flag stays up until the next supply rise
   property p_done_sticky;
      @(posedge clk_sys) disable iff (rst)
      done_q |=> done_q;
   endproperty
   a_done_sticky: assert property (p_done_sticky)
      else $error("recall flag dropped");

   // the timer parks at its end value, so it cannot wrap and recall twice
   property p_timer_frozen;
      @(posedge clk_sys) disable iff (rst)
      done_q |=> $stable(pu_cnt_q);
   endproperty
   a_timer_frozen: assert property (p_timer_frozen)
      else $error("recall timer kept running");

   // while waiting the timer never passes the programmed delay
   property p_timer_bound;
      @(posedge clk_sys) disable iff (rst)
      !done_q |-> (pu_cnt_q < CW'(RECALL_CYCLES));
   endproperty
   a_timer_bound: assert property (p_timer_bound)
      else $error("recall timer overran");

   // without a write the selected tap stands; the wiper only moves on request
   property p_wiper_holds;
      @(posedge clk_sys) disable iff (rst)
      (done_q && !wiper_write) |=> $stable(wiper_q);
   endproperty
   a_wiper_holds: assert property (p_wiper_holds)
      else $error("wiper moved without a write");

   // reset stands for the supply rise: nothing selected, no recall yet
   property p_reset_state;
      @(posedge clk_sys)
      rst |-> (!done_q && wiper_q == '0 && pu_cnt_q == '0);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("state not cleared in reset");
endmodule
`default_nettype wire

// File: tb/ptpe_host_model.sv
// host side model: turns tap positions into wiper setting bytes
`timescale 1ns/1ps
`default_nettype none
module ptpe_host_model (
   input  wire logic signed [31:0] pos,
   input  wire logic               raw_en,
   input  wire logic [7:0]         raw_code,
   output logic [7:0]              code
);
   // clamp before encoding so every position gives a legal byte; raw_en sends any byte
   always_comb
   begin
      if (raw_en) code = raw_code;
      else if (pos < 0) code = 8'h00;
      else if (pos > 8'h63) code = 8'h60;
      else if (pos > 8'h4a) code = 8'hc3 - pos[7:0];
      else if (pos > 8'h31) code = 8'h0e + pos[7:0];
      else if (pos > 8'h18) code = 8'h51 - pos[7:0];
      else code = pos[7:0];
   end
endmodule
`default_nettype wire

// File: tb/test_pot_tap_position_encoder.sv
// self-checking bench for the tap position codec and its power-up recall
`timescale 1ns/1ps
`default_nettype none
module test_pot_tap_position_encoder;
   import ptpe_pkg::*;
   localparam int unsigned RCYC = 7000; // shortest legal recall
   logic              clk_sys, rst, wiper_write, raw_en, recall_done;
   logic              pend = 1'b0;
   logic [7:0]        raw_code, stored_code, wiper_code, seen, exp_v;
   logic signed [31:0] pos;
   logic [31:0]       lfsr = 32'h140c;
   ptpe_wiper_type    out;
   logic [7:0]        expq[$];
   int                errors, checks_done, n, t;
   ptpe_tap_codec #(.RECALL_CYCLES(RCYC)) dut_u (.clk_sys(clk_sys), .rst(rst),
      .wiper_code(wiper_code), .wiper_write(wiper_write), .stored_code(stored_code),
      .recall_done(recall_done), .fine_step_potentiometer(out));
   ptpe_host_model host_u (.pos(pos), .raw_en(raw_en), .raw_code(raw_code), .code(wiper_code));
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string what, input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   // one write per cycle; expectation queued as the request goes out
   task automatic wr(input int p, input logic r, input logic [7:0] c, input logic [7:0] e);
      pos <= p;
      raw_en <= r;
      raw_code <= c;
      wiper_write <= 1'b1;
      expq.push_back(e);
      @(posedge clk_sys);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // an accepted write shows one edge later; undefined codes compare on valid only
   always @(posedge clk_sys) pend <= wiper_write & recall_done;
   always @(negedge clk_sys)
      if (pend)
      begin
         seen = out.valid ? out : 8'h00;
         exp_v = expq.size() ? expq.pop_front() : 8'hff;
         check("wiper", 16'(seen), 16'(exp_v));
      end
   // watchdog so a stuck recall cannot hang the run
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      wrap_up();
   end
   initial
   begin
      rst = 1'b1;
      wiper_write = 1'b0;
      raw_en = 1'b0;
      raw_code = 8'h00;
      stored_code = 8'h00;
      lfsr = lfsr_next(lfsr);
      t = int'(lfsr % 100);
      pos = t;
      @(posedge clk_sys);
      stored_code <= wiper_code;
      repeat (7) @(posedge clk_sys);
      rst <= 1'b0;
      raw_en <= 1'b1; // a foreign code, so a leaked write cannot pass for the recall
      raw_code <= 8'h05;
      wiper_write <= 1'b1; // held through recall: must be dropped
      n = 0;
      while (recall_done !== 1'b1 && n < 13100)
      begin
         @(posedge clk_sys);
         n++;
         #1 if (recall_done !== 1'b1)
            check("wiper before recall", {8'h00, out}, 16'h0000);
      end
      wiper_write <= 1'b0;
      raw_en <= 1'b0;
      check("recall cycles", 16'(n), 16'(RCYC));
      check("recalled wiper", {8'h00, out}, {8'h00, 1'b1, 7'(t)});
      $display("test recall done");
      @(posedge clk_sys);
      for (int p = 0; p < 100; p++) wr(p, 1'b0, 8'h00, {1'b1, 7'(p)});
      $display("test all taps done");
      wr(-5, 1'b0, 8'h00, 8'h80);
      wr(150, 1'b0, 8'h00, 8'he3);
      $display("test clamp done");
      for (int k = 0; k < 8; k++)
         wr(0, 1'b1, 8'h19 + 8'(k[0] ? 8'h06 : 8'h00) + 8'(k[2:1] * 8'h20), 8'h00);
      wr(0, 1'b1, 8'hff, 8'h00);
      $display("test undefined codes done");
      repeat (50)
      begin
         lfsr = lfsr_next(lfsr);
         t = int'(lfsr % 100);
         wr(t, 1'b0, 8'h00, {1'b1, 7'(t)});
      end
      wiper_write <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check("pending results", 16'(expq.size()), 16'h0000);
      $display("test random taps done");
      wrap_up();
   end
endmodule
`default_nettype wire
